/* bonded_rx_sync_status_fsm.sv */
/*
  Per-channel receive synchronization machine for bonded channels, with
  Type-A and Type-B status forms, feeding a status/data FIFO.
  Assumes decoder flags are synchronous to clk and valid with char_valid.
*/
//
// Contract
// [RL1] Machine is enabled whenever bond mode select bit 1 is high.
// [RL2] Bonding off (modes 0, 1): machine disabled, independent-mode status reported.
// [RL3] Machine tracks framing loss and recovery and helps control bonding.
// [RL4] Two machine variants exist; selected type and bonding mode govern status output.
// [RL5] Type-A: four states; only locked state emits several codes.
// [RL6] Type-B: same four states; some emit one code, some several.
// [RL7] Code 000 for valid data character.
// [RL8] Code 001 for valid special character, not framing nor violation.
// [RL9] Type-A: code 010 when elasticity buffer fails add/drop.
// [RL10] Type-B: code 010 channel lock, only on last cycle before aligned data.
// [RL11] Code 011 for framing character, decoded value on bus.
// [RL12] Overlapping conditions report exactly one code by fixed priority.
// [RL13] Bond mode select bit 0 chooses Type-A or Type-B reporting.
// [RL14] Code 101 when synchronization or bonded alignment is lost.
// [RL15] Code 111 while realigning; bus carries decoded framing character.
// [RL16] Lower priority number wins among overlapping conditions.
`timescale 1ns/1ns
`include "rx_sync_map.svh"
module bonded_rx_sync_status_fsm (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire rx_sync_pkg::mode_t   rx_bond_mode_select,
  input  wire logic                 char_valid,
  input  wire logic [7:0]           char_data,
  input  wire logic                 char_special,
  input  wire logic                 char_framing,
  input  wire logic                 codeword_err,
  input  wire logic                 disparity_err,
  input  wire logic                 eb_fault,
  input  wire logic                 pll_unlock,
  input  wire logic                 bond_inhibit_n,
  input  wire logic                 deskew_expired,
  input  wire logic                 master_bonded,
  output logic                      char_ready,
  output logic [7:0]                out_data,
  output rx_sync_pkg::status_t      rx_status_code,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output rx_sync_pkg::sync_state_e  sync_state
);
  import rx_sync_pkg::*;

  sync_state_e state_q;
  sync_state_e state_d;
  logic [2:0]  frame_run_q;
  logic [2:0]  err_run_q;
  logic [3:0]  inv_q;
  logic        bond_on;
  logic        type_b;
  logic        dec_err;
  logic        step;
  status_t     code;
  logic        fifo_in_ready;
  logic [10:0] fifo_out;

  // Independent-mode / locked per-character status by priority
  function automatic status_t char_code(input logic eb, input logic cw,
                                        input logic rd, input logic fr,
                                        input logic sp, input logic tb);
    if (eb && !tb) begin
      char_code = `ST_EB_OR_LOCK;   // [RL9] [RL16]
    end else if (eb) begin
      char_code = `ST_LOSS_SYNC;
    end else if (cw) begin
      char_code = `ST_CODEWORD;
    end else if (fr) begin
      char_code = `ST_FRAMING;      // [RL11]
    end else if (rd) begin
      char_code = `ST_DISPARITY;
    end else if (sp) begin
      char_code = `ST_SPECIAL;      // [RL8]
    end else begin
      char_code = `ST_NORMAL;       // [RL7]
    end
  endfunction

  assign bond_on    = rx_bond_mode_select[`BOND_MODE_BIT];   // [RL1] [RL2]
  assign type_b     = rx_bond_mode_select[`TYPE_SEL_BIT];    // [RL13] [RL4]
  assign dec_err    = codeword_err || disparity_err;
  assign step       = char_valid && fifo_in_ready;
  assign char_ready = fifo_in_ready;
  assign sync_state = state_q;
  assign out_data       = fifo_out[10:3];
  assign rx_status_code = fifo_out[2:0];

  // Next state, Type-A and Type-B forms [RL3] [RL5] [RL6]
  always_comb begin
    state_d = state_q;
    case (state_q)
      state_unsynced: begin
        if (char_framing) begin
          state_d = state_realigning;
        end
      end
      state_realigning: begin
        if (eb_fault || pll_unlock || dec_err) begin
          state_d = state_unsynced;
        end else if (deskew_expired && (!bond_inhibit_n || (type_b && !master_bonded))) begin
          state_d = state_bond_failed;
        end else if (!type_b && char_valid && !char_framing && !char_special) begin
          state_d = state_locked;
        end else if (type_b && char_framing && master_bonded && frame_run_q == `FRAME_RUN_MAX) begin
          state_d = state_locked;
        end
      end
      state_bond_failed: begin
        if (eb_fault || pll_unlock) begin
          state_d = state_unsynced;
        end
      end
      state_locked: begin
        if (eb_fault || pll_unlock || err_run_q == `ERR_RUN_MAX ||
            inv_q == `INV_MINUS_VAL) begin
          state_d = state_unsynced;
        end
      end
      default: state_d = state_unsynced;
    endcase
    if (!bond_on) begin
      state_d = state_unsynced;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= state_unsynced;
    end else if (step || !bond_on) begin
      state_q <= state_d;
    end
  end

  // Consecutive framing character count
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_run_q <= '0;
    end else if (step) begin
      if (!char_framing) begin
        frame_run_q <= '0;
      end else if (frame_run_q != `FRAME_RUN_MAX) begin
        frame_run_q <= frame_run_q + 3'h1;
      end
    end
  end

  // Consecutive decoder errors and invalid-minus-valid tally
  always_ff @(posedge clk) begin
    if (rst || state_q != state_locked) begin
      err_run_q <= '0;
      inv_q     <= '0;
    end else if (step) begin
      err_run_q <= dec_err ? err_run_q + 3'h1 : 3'h0;
      if (dec_err) begin
        inv_q <= inv_q + 4'h1;
      end else if (inv_q != 4'h0) begin
        inv_q <= inv_q - 4'h1;
      end
    end
  end

  // One status code per character [RL12]
  always_comb begin
    code = char_code(eb_fault, codeword_err, disparity_err, char_framing,
                     char_special, type_b);
    if (bond_on) begin
      case (state_q)
        state_unsynced:    code = `ST_LOSS_SYNC;                  // [RL14]
        state_bond_failed: code = `ST_LOSS_SYNC;                  // [RL14]
        state_realigning: begin
          if (type_b && state_d == state_locked) begin
            code = `ST_EB_OR_LOCK;                                // [RL10]
          end else begin
            code = `ST_RESYNC;                                    // [RL15]
          end
        end
        state_locked: begin
          if (pll_unlock || (type_b && eb_fault)) begin
            code = `ST_LOSS_SYNC;                                 // [RL14]
          end
        end
        default: code = `ST_LOSS_SYNC;
      endcase
    end
  end

  rx_status_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   ({char_data, code}),
    .in_valid  (char_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

  a_disabled_idle: assert property (@(posedge clk) disable iff (rst)
    !bond_on |=> state_q == state_unsynced)                      // [RL2]
    else $error("machine not idle with bonding off");
  a_resync_code: assert property (@(posedge clk) disable iff (rst)
    bond_on && state_q == state_realigning && state_d != state_locked
    |-> code == `ST_RESYNC)                                      // [RL15]
    else $error("realigning without resync code");
  a_unsync_code: assert property (@(posedge clk) disable iff (rst)
    bond_on && state_q == state_unsynced |-> code == `ST_LOSS_SYNC) // [RL14]
    else $error("unsynced without loss code");
  a_lock_once: assert property (@(posedge clk) disable iff (rst)
    step && bond_on && code == `ST_EB_OR_LOCK && type_b
    |=> state_q == state_locked)                                 // [RL10]
    else $error("lock code not followed by locked state");
  a_eb_type_a: assert property (@(posedge clk) disable iff (rst)
    !type_b && eb_fault && (!bond_on || (state_q == state_locked && !pll_unlock))
    |-> code == `ST_EB_OR_LOCK)                                  // [RL9]
    else $error("buffer fault code missing");
  a_framing_code: assert property (@(posedge clk) disable iff (rst)
    !bond_on && char_framing && !eb_fault && !codeword_err
    |-> code == `ST_FRAMING)                                     // [RL11]
    else $error("framing code missing");
  a_normal_code: assert property (@(posedge clk) disable iff (rst)
    !bond_on && !eb_fault && !dec_err && !char_framing && !char_special
    |-> code == `ST_NORMAL)                                      // [RL7]
    else $error("normal code missing");
  a_special_code: assert property (@(posedge clk) disable iff (rst)
    !bond_on && char_special && !eb_fault && !dec_err && !char_framing
    |-> code == `ST_SPECIAL)                                     // [RL8]
    else $error("special code missing");
  a_lock_loss: assert property (@(posedge clk) disable iff (rst)
    bond_on && step && state_q == state_locked && pll_unlock
    |=> state_q == state_unsynced)                               // [RL3]
    else $error("locked state kept after pll unlock");
endmodule

/* rx_sync_map.svh */
/*
  Constants for the bonded receive synchronization status block.
  Assumes inclusion by bare name from the bonded_rx_sync_status_fsm module only.
*/
`ifndef RX_SYNC_MAP_SVH
`define RX_SYNC_MAP_SVH
`define ST_NORMAL      3'h0
`define ST_SPECIAL     3'h1
`define ST_EB_OR_LOCK  3'h2
`define ST_FRAMING     3'h3
`define ST_CODEWORD    3'h4
`define ST_LOSS_SYNC   3'h5
`define ST_DISPARITY   3'h6
`define ST_RESYNC      3'h7
`define BOND_MODE_BIT  1
`define TYPE_SEL_BIT   0
`define FRAME_RUN_MAX  3'h4
`define ERR_RUN_MAX    3'h4
`define INV_MINUS_VAL  4'h4
`define FIFO_DEPTH     16
`define FIFO_WIDTH     11
`endif

/* rx_sync_pkg.sv */
/*
  Types for the bonded receive synchronization status block.
  Assumes rx_sync_map.svh is on the include path.
*/
package rx_sync_pkg;
  typedef enum logic [1:0] {
    state_unsynced,
    state_realigning,
    state_bond_failed,
    state_locked
  } sync_state_e;
  typedef logic [2:0] status_t;
  typedef logic [1:0] mode_t;
endpackage

/* rx_status_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides; read data from a register.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module rx_status_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  logic             empty;

  assign empty    = (cnt_q == '0);
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign pop      = out_ready || !out_valid;
  assign push     = in_valid && in_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= !empty;
      if (!empty) begin
        out_data <= mem[rd_q];
        rd_q     <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop && !empty);
    end
  end
endmodule

/* rx_host_model.sv */
/*
  Host-side sink of the receive output bus; stall holds off out_ready.
  Assumes one clock; accepted words queue in got in arrival order.
*/
`timescale 1ns/1ns
module rx_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic [2:0] rx_status_code,
  output logic            out_ready
);
  logic [10:0] got [$];
  assign out_ready = !stall;
  always @(posedge clk) begin
    if (rst) got.delete();
    else if (out_valid && out_ready) got.push_back({out_data, rx_status_code});
  end
endmodule

/* bonded_rx_sync_status_fsm_tb.sv */
/*
  Self-checking bench: table of unbonded cases, then bonded sequences.
  Assumes the design and rx_host_model; flags {sp,fr,cw,dp,eb,pll}.
*/
`timescale 1ns/1ns
module bonded_rx_sync_status_fsm_tb;
  import rx_sync_pkg::*;
  typedef struct packed {mode_t m; logic [5:0] f; status_t c;} row_s;
  logic        clk, rst, char_valid, char_special, char_framing, codeword_err;
  logic        disparity_err, eb_fault, pll_unlock, bond_inhibit_n, deskew_expired;
  logic        master_bonded, stall, char_ready, out_valid, out_ready;
  mode_t       rx_bond_mode_select;
  logic [7:0]  char_data, out_data;
  status_t     rx_status_code;
  sync_state_e sync_state;
  int          fail_count, compares;
  logic [11:0] exp_q [$];
  row_s        rows [12];
  bonded_rx_sync_status_fsm bonded_rx_sync_status_fsm_inst (
    .clk                 (clk),
    .rst                 (rst),
    .rx_bond_mode_select (rx_bond_mode_select),
    .char_valid          (char_valid),
    .char_data           (char_data),
    .char_special        (char_special),
    .char_framing        (char_framing),
    .codeword_err        (codeword_err),
    .disparity_err       (disparity_err),
    .eb_fault            (eb_fault),
    .pll_unlock          (pll_unlock),
    .bond_inhibit_n      (bond_inhibit_n),
    .deskew_expired      (deskew_expired),
    .master_bonded       (master_bonded),
    .char_ready          (char_ready),
    .out_data            (out_data),
    .rx_status_code      (rx_status_code),
    .out_valid           (out_valid),
    .out_ready           (out_ready),
    .sync_state          (sync_state)
  );
  rx_host_model rx_host_model_inst (.clk(clk), .rst(rst), .stall(stall),
    .out_valid(out_valid), .out_data(out_data), .rx_status_code(rx_status_code),
    .out_ready(out_ready));
  task automatic check(string what, logic [10:0] e, logic [10:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic drive(logic [5:0] f, logic v);
    @(negedge clk);
    {char_special, char_framing, codeword_err, disparity_err, eb_fault, pll_unlock} = f;
    char_valid = v;
  endtask
  task automatic send(logic [5:0] f, logic [7:0] d, logic k, status_t c);
    int n;
    drive(f, 1'b1);
    char_data = d;
    n = 0;
    while (char_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    exp_q.push_back({k, d, c});
  endtask
  task automatic drain;
    int n;
    logic [11:0] e;
    logic [10:0] s;
    drive(6'h00, 1'b0);
    n = 0;
    while (rx_host_model_inst.got.size() < exp_q.size() && n < 200) begin
      @(negedge clk);
      n++;
    end
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      s = rx_host_model_inst.got.size() ? rx_host_model_inst.got.pop_front() : 'x;
      check("out_data", {3'h0, e[10:3]}, {3'h0, s[10:3]});
      if (e[11]) check("rx_status_code", {8'h0, e[2:0]}, {8'h0, s[2:0]});
    end
  endtask
  task automatic state_is(sync_state_e e);
    drive(6'h00, 1'b0);
    check("sync_state", 11'(e), 11'(sync_state));
  endtask
  task automatic reset_dut;
    drive(6'h00, 1'b0);
    rst = 1;
    @(negedge clk);
    rst = 0;
    exp_q.delete();
    check("out_valid", 11'h0, {10'h0, out_valid});
    check("char_ready", 11'h1, {10'h0, char_ready});
    check("sync_state", 11'(state_unsynced), 11'(sync_state));
  endtask
  task automatic complete_run;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    complete_run;
  end
  initial begin
    {rst, stall, char_data, rx_bond_mode_select, bond_inhibit_n} = {1'b1, 1'b0, 8'h0, 2'h0, 1'b1};
    {deskew_expired, master_bonded, fail_count, compares} = 0;
    drive(6'h00, 1'b0);
    rows = '{'{0, 6'h00, 0}, '{0, 6'h20, 1}, '{0, 6'h10, 3}, '{0, 6'h08, 4},
             '{0, 6'h04, 6}, '{0, 6'h02, 2}, '{1, 6'h02, 5}, '{0, 6'h18, 4},
             '{0, 6'h24, 6}, '{0, 6'h14, 3}, '{1, 6'h00, 0}, '{0, 6'h0a, 2}};
    reset_dut;
    foreach (rows[i]) begin
      drive(6'h00, 1'b0);
      rx_bond_mode_select = rows[i].m;
      send(rows[i].f, 8'h10 + 8'(i), 1, rows[i].c);
    end
    drain;
    rx_bond_mode_select = 2'b10;
    reset_dut;
    send(6'h00, 8'ha0, 1, 5);
    send(6'h10, 8'hbc, 0, 0);
    send(6'h10, 8'hbc, 1, 7);
    send(6'h00, 8'ha1, 0, 0);
    state_is(state_locked);
    send(6'h00, 8'ha2, 1, 0);
    send(6'h20, 8'ha3, 1, 1);
    send(6'h10, 8'hbc, 1, 3);
    send(6'h02, 8'ha4, 1, 2);
    send(6'h00, 8'ha5, 1, 5);
    send(6'h10, 8'hbc, 0, 0);
    drive(6'h00, 1'b0);
    {deskew_expired, bond_inhibit_n} = 2'b10;
    send(6'h10, 8'hbc, 0, 0);
    state_is(state_bond_failed);
    {deskew_expired, bond_inhibit_n} = 2'b01;
    send(6'h00, 8'ha6, 1, 5);
    drain;
    rx_bond_mode_select = 2'b11;
    reset_dut;
    repeat (5) send(6'h10, 8'hbc, 0, 0);
    state_is(state_realigning);
    master_bonded = 1;
    send(6'h10, 8'hbc, 1, 2);
    repeat (3) send(6'h10, 8'hbc, 0, 0);
    state_is(state_locked);
    send(6'h00, 8'hb0, 1, 0);
    send(6'h01, 8'hb1, 1, 5);
    drain;
    stall = 1;
    for (int i = 0; i < 17; i++) send(6'h00, 8'(i), 1, 5);
    drive(6'h00, 1'b0);
    check("char_ready", 11'h0, {10'h0, char_ready});
    stall = 0;
    drain;
    stall = 1;
    repeat (3) send(6'h00, 8'hc0, 0, 0);
    reset_dut;
    complete_run;
  end
endmodule
